// ### shared/adcdt_pkg.sv
// Package: constants, register map and types for the delayed trigger sweep sequencer
// Contract
// - B0 underflow starts single sweep at input 0
// - Input 1 waits for B1 underflow
// - B0 again before B1 is ignored
// - B0 during input 1+ restarts sweep
// - Early B1 samples input 1, converts later
// - Stop at sweep end or start flag cleared
// - Sweep 2, 4, 6 or 8 inputs
// - Result stored per input pin register
// - Start flag reads conversion state
// - Resolution selectable 8 or 10 bits
package adcdt_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int RES_W = 10;
  localparam int NUM_IN = 8;

  // ***********************************************
  // Register offsets
  // ***********************************************
  localparam logic [ADDR_W-1:0] OFS_CONTROL_0 = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_1 = 5'h01;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_2 = 5'h02;
  localparam logic [ADDR_W-1:0] OFS_STATUS_0 = 5'h03;
  localparam logic [ADDR_W-1:0] OFS_TRIG_CTRL = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h05;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 5'h06;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 5'h07;
  localparam logic [ADDR_W-1:0] OFS_RESULT_0 = 5'h10;

  // ***********************************************
  // Field positions and reset values
  // ***********************************************
  localparam int BIT_START = 6;
  localparam int BIT_SEL_LO = 0;
  localparam int BIT_SEL_HI = 1;
  localparam int BIT_RES10 = 3;
  localparam int BIT_GRP_LO = 1;
  localparam int BIT_GRP_HI = 2;
  localparam int BIT_DLY_EN = 0;
  localparam int BIT_ST_BUSY = 0;
  localparam int BIT_ST_WAIT = 1;
  localparam int BIT_ST_HELD = 2;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_RESTART = 1;
  localparam int IRQ_IGNORED = 2;
  localparam logic [7:0] RST_CONTROL = 8'h00;

  // Conversion length in operating clocks: 8-bit and 10-bit resolution
  localparam logic [7:0] CONV_CYC_8 = 8'h1C;
  localparam logic [7:0] CONV_CYC_10 = 8'h21;

  typedef enum logic [2:0] {
    ADCDT_IDLE,
    ADCDT_CONV0,
    ADCDT_WAIT_B1,
    ADCDT_CONV_N
  } adcdt_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adcdt_bus_t;

  typedef struct packed {
    logic b0_uflow;
    logic b1_uflow;
  } adcdt_trig_t;

  // Converter core side: one start pulse, result with done pulse
  typedef struct packed {
    logic [2:0] chan;
    logic [1:0] group;
    logic start;
    logic sample;
  } adcdt_core_req_t;

endpackage : adcdt_pkg

// ### rtl/adcdt_result_mem.sv
// Small result memory, one word per input pin, registered read port
`timescale 1ns/10ps
module adcdt_result_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 10
) (
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // No reset on the array: results read undefined until first converted
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : adcdt_result_mem

// ### rtl/adcdt_sweep.sv
// Delayed trigger sweep sequencer with register port and converter core handshake
`timescale 1ns/10ps
module adcdt_sweep (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire adcdt_pkg::adcdt_bus_t bus,
  output logic [adcdt_pkg::DATA_W-1:0] rdata,
  input wire adcdt_pkg::adcdt_trig_t trig,
  output adcdt_pkg::adcdt_core_req_t core_req,
  input wire logic core_done,
  input wire logic [adcdt_pkg::RES_W-1:0] core_data,
  output logic irq
);
  import adcdt_pkg::*;

  // ***********************************************
  // Registers
  // ***********************************************
  adcdt_state_t state_q, state_d;
  logic start_q;
  logic [7:0] ctl1_q;
  logic [7:0] ctl2_q;
  logic dly_en_q;
  logic [2:0] chan_q;
  logic held_q;
  logic [7:0] cnt_q;
  logic [IRQ_W-1:0] irq_stat_q, irq_en_q;
  logic [ADDR_W-1:0] raddr_q;
  logic rd_q;
  adcdt_core_req_t req_q;

  // ***********************************************
  // Decode
  // ***********************************************
  wire wr_c0 = bus.wr && bus.addr == OFS_CONTROL_0;
  wire wr_c1 = bus.wr && bus.addr == OFS_CONTROL_1;
  wire wr_c2 = bus.wr && bus.addr == OFS_CONTROL_2;
  wire wr_tc = bus.wr && bus.addr == OFS_TRIG_CTRL;
  wire wr_ie = bus.wr && bus.addr == OFS_IRQ_EN;
  wire wr_ic = bus.wr && bus.addr == OFS_IRQ_CLR;

  // Last swept channel: 1, 3, 5 or 7
  function automatic logic [2:0] last_chan(input logic [1:0] sel);
    return {sel, 1'b1};
  endfunction : last_chan

  wire [1:0] sweep_sel = {ctl1_q[BIT_SEL_HI], ctl1_q[BIT_SEL_LO]};
  wire [2:0] chan_last = last_chan(sweep_sel);
  wire [1:0] group = {ctl2_q[BIT_GRP_HI], ctl2_q[BIT_GRP_LO]};
  wire res10 = ctl1_q[BIT_RES10];
  wire [7:0] conv_len = res10 ? CONV_CYC_10 : CONV_CYC_8;
  wire b0 = trig.b0_uflow && dly_en_q;
  wire b1 = trig.b1_uflow && dly_en_q;
  // Software clearing the start flag halts the sweep
  wire sw_stop = wr_c0 && !bus.wdata[BIT_START];
  wire conv_end = core_done;
  wire last_done = conv_end && state_q == ADCDT_CONV_N && chan_q == chan_last;
  wire restart = b0 && state_q == ADCDT_CONV_N;
  wire ignored = b0 && (state_q == ADCDT_CONV0 || state_q == ADCDT_WAIT_B1);

  // ***********************************************
  // Sequencer
  // ***********************************************
  always_comb begin
    state_d = state_q;
    if (sw_stop) begin
      state_d = ADCDT_IDLE;
    end else begin
      case (state_q)
        ADCDT_IDLE: begin
          if (b0) begin
            state_d = ADCDT_CONV0;
          end
        end
        ADCDT_CONV0: begin
          if (conv_end) begin
            state_d = (held_q || b1) ? ADCDT_CONV_N : ADCDT_WAIT_B1;
          end
        end
        ADCDT_WAIT_B1: begin
          if (b1) begin
            state_d = ADCDT_CONV_N;
          end
        end
        ADCDT_CONV_N: begin
          if (b0) begin
            state_d = ADCDT_CONV0;
          end else if (last_done) begin
            state_d = ADCDT_IDLE;
          end
        end
        default: state_d = ADCDT_IDLE;
      endcase
    end
  end

  wire enter_c0 = state_d == ADCDT_CONV0 && (state_q != ADCDT_CONV0);
  wire next_n = state_d == ADCDT_CONV_N &&
    (state_q != ADCDT_CONV_N || (conv_end && chan_q != chan_last));
  wire launch = enter_c0 || next_n;
  wire [2:0] chan_d = enter_c0 ? 3'h0 : (state_q == ADCDT_CONV_N ? chan_q + 3'h1 : 3'h1);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ADCDT_IDLE;
      chan_q <= 3'h0;
      held_q <= 1'b0;
      cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (launch) begin
        chan_q <= chan_d;
        cnt_q <= conv_len;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
      // Early B1 during first input: input 1 is sampled now, converted later
      if (state_d != ADCDT_CONV0) begin
        held_q <= 1'b0;
      end else if (b1 && state_q == ADCDT_CONV0) begin
        held_q <= 1'b1;
      end
    end
  end

  // ***********************************************
  // Converter core request
  // ***********************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_q <= '0;
    end else begin
      req_q.start <= launch;
      req_q.chan <= launch ? chan_d : req_q.chan;
      req_q.group <= group;
      // A stop in the same cycle wins: no sample once the sweep is dropped
      req_q.sample <= b1 && state_q == ADCDT_CONV0 && !sw_stop;
    end
  end
  assign core_req = req_q;

  // Start flag: set by first trigger, dropped at sweep end or software clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      start_q <= 1'b0;
    end else begin
      start_q <= state_d != ADCDT_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl1_q <= RST_CONTROL;
      ctl2_q <= RST_CONTROL;
      dly_en_q <= 1'b0;
    end else begin
      if (wr_c1) begin
        ctl1_q <= bus.wdata;
      end
      if (wr_c2) begin
        ctl2_q <= bus.wdata;
      end
      if (wr_tc) begin
        dly_en_q <= bus.wdata[BIT_DLY_EN];
      end
    end
  end

  // ***********************************************
  // Results
  // ***********************************************
  wire [RES_W-1:0] res_val = res10 ? core_data : {2'b00, core_data[RES_W-1:2]};
  wire res_we = conv_end && (state_q == ADCDT_CONV0 || state_q == ADCDT_CONV_N) && !restart;
  wire [RES_W-1:0] mem_rdata;
  wire res_hit = raddr_q >= OFS_RESULT_0 && raddr_q < OFS_RESULT_0 + 5'h08;
  wire [ADDR_W-1:0] res_idx = bus.addr - OFS_RESULT_0;

  adcdt_result_mem #(.DEPTH(NUM_IN), .WIDTH(RES_W)) u_mem (
    .sys_clk(sys_clk),
    .we(res_we),
    .waddr(chan_q),
    .wdata(res_val),
    .raddr(res_idx[2:0]),
    .rdata(mem_rdata)
  );

  // ***********************************************
  // Interrupts: set wins over clear
  // ***********************************************
  wire [IRQ_W-1:0] ev = {ignored, restart, last_done};
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_q <= '0;
      irq_en_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_ic ? bus.wdata[IRQ_W-1:0] : 3'h0)) | ev;
      if (wr_ie) begin
        irq_en_q <= bus.wdata[IRQ_W-1:0];
      end
    end
  end
  assign irq = |(irq_stat_q & irq_en_q);

  // ***********************************************
  // Read port
  // ***********************************************
  wire [7:0] stat_v = {5'h00, held_q, state_q == ADCDT_WAIT_B1, state_q != ADCDT_IDLE};
  logic [DATA_W-1:0] reg_v;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      raddr_q <= '0;
      rd_q <= 1'b0;
      reg_v <= '0;
    end else begin
      raddr_q <= bus.addr;
      rd_q <= bus.rd;
      if (bus.addr == OFS_CONTROL_0) begin
        reg_v <= {9'h000, start_q, 6'h00};
      end else if (bus.addr == OFS_CONTROL_1) begin
        reg_v <= {8'h00, ctl1_q};
      end else if (bus.addr == OFS_CONTROL_2) begin
        reg_v <= {8'h00, ctl2_q};
      end else if (bus.addr == OFS_STATUS_0) begin
        reg_v <= {8'h00, stat_v};
      end else if (bus.addr == OFS_TRIG_CTRL) begin
        reg_v <= {15'h0000, dly_en_q};
      end else if (bus.addr == OFS_IRQ_STAT) begin
        reg_v <= {13'h0000, irq_stat_q};
      end else if (bus.addr == OFS_IRQ_EN) begin
        reg_v <= {13'h0000, irq_en_q};
      end else begin
        reg_v <= '0;
      end
    end
  end
  assign rdata = !rd_q ? '0 : res_hit ? {6'h00, mem_rdata} : reg_v;
endmodule : adcdt_sweep

// ### testbench/adcdt_core_model.sv
// Converter core model answering start pulses after a short or long delay
`timescale 1ns/10ps
module adcdt_core_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire adcdt_pkg::adcdt_core_req_t core_req,
  input wire logic slow,
  output logic core_done,
  output logic [adcdt_pkg::RES_W-1:0] core_data
);
  import adcdt_pkg::*;
  logic [5:0] cnt_q;
  logic [RES_W-1:0] val_q;
  // A new start aborts the conversion in flight
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 6'h00;
      val_q <= '0;
    end else if (core_req.start) begin
      cnt_q <= slow ? 6'h28 : 6'h06;
      val_q <= {core_req.chan, 7'h35};
    end else if (cnt_q != 6'h00) begin
      cnt_q <= cnt_q - 6'h01;
    end
  end
  assign core_done = cnt_q == 6'h01;
  // Off the done cycle the lines show the inverse, never a stale match
  assign core_data = core_done ? val_q : ~val_q;
endmodule : adcdt_core_model

// ### testbench/adcdt_sweep_monitor.sv
// Port checker for the delayed trigger sweep sequencer
`timescale 1ns/10ps
module adcdt_sweep_monitor (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire adcdt_pkg::adcdt_bus_t bus,
  input wire logic [adcdt_pkg::DATA_W-1:0] rdata,
  input wire adcdt_pkg::adcdt_trig_t trig,
  input wire adcdt_pkg::adcdt_core_req_t core_req,
  input wire logic core_done,
  input wire logic [adcdt_pkg::RES_W-1:0] core_data,
  input wire logic irq
);
  import adcdt_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic first_q;
  logic [2:0] last_q;
  wire go0 = core_req.start && core_req.chan == 3'h0;
  wire stop_wr = bus.wr && bus.addr == OFS_CONTROL_0;
  // ******************************
  // First input phase tracking
  // ******************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      first_q <= 1'b0;
      last_q <= 3'h0;
    end else if (core_req.start) begin
      first_q <= go0;
      last_q <= core_req.chan;
    end else if (stop_wr) begin
      first_q <= 1'b0;
    end
  end
  a_read_idle: assert property (!$past(bus.rd) |-> rdata == '0) else $error("rdata not idle");
  a_start_single: assert property (core_req.start |=> !core_req.start)
    else $error("start too long");
  a_first_cause: assert property (go0 |-> $past(trig.b0_uflow)) else $error("input 0 uncaused");
  a_second_cause: assert property (core_req.start && core_req.chan == 3'h1
    |-> $past(trig.b1_uflow) || $past(core_done)) else $error("input 1 early");
  a_later_cause: assert property (core_req.start && core_req.chan > 3'h1 |-> $past(core_done))
    else $error("later input early");
  a_chan_order: assert property (core_req.start && core_req.chan != 3'h0
    |-> core_req.chan == last_q + 3'h1) else $error("input skipped");
  // The cycle that shows input 1's start already belongs to the later inputs
  a_b0_ignored: assert property (first_q && !core_req.start && trig.b0_uflow |=> !go0)
    else $error("B0 not ignored");
  a_irq_cause: assert property ($rose(irq) |-> $past(core_done) || $past(core_done, 2)
    || $past(trig.b0_uflow) || $past(bus.wr) || $past(bus.wr, 2))
    else $error("irq uncaused");
  a_sample_cause: assert property (core_req.sample |-> $past(trig.b1_uflow))
    else $error("sample uncaused");
  c_sample: cover property (core_req.sample);
  c_restart: cover property (go0 && last_q != 3'h0);
  c_irq: cover property ($rose(irq));
endmodule : adcdt_sweep_monitor
bind adcdt_sweep adcdt_sweep_monitor adcdt_sweep_monitor_i (.sys_clk(sys_clk), .rst_b(rst_b),
  .bus(bus), .rdata(rdata), .trig(trig), .core_req(core_req), .core_done(core_done),
  .core_data(core_data), .irq(irq));

// ### testbench/adcdt_sweep_bench.sv
// Self-checking bench for the delayed trigger sweep sequencer
`timescale 1ns/10ps
module adcdt_sweep_bench;
  import adcdt_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  adcdt_bus_t bus = '0;
  adcdt_trig_t trig = '0;
  logic [DATA_W-1:0] rdata;
  adcdt_core_req_t core_req;
  logic core_done;
  logic [RES_W-1:0] core_data;
  logic irq;
  logic slow = 1'b0;
  logic [15:0] got;
  int n_errors = 0;
  int total_checks = 0;
  int seed = 32'hd6d3;
  int i;
  int k;
  adcdt_sweep adcdt_sweep_i (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
    .trig(trig), .core_req(core_req), .core_done(core_done), .core_data(core_data), .irq(irq));
  adcdt_core_model adcdt_core_model_i (.sys_clk(sys_clk), .rst_b(rst_b), .core_req(core_req),
    .slow(slow), .core_done(core_done), .core_data(core_data));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  // ******************************
  // Bus and check helpers
  // ******************************
  function automatic logic [15:0] exp_res(input logic [2:0] ch, input logic r10);
    logic [9:0] v;
    v = {ch, 7'h35};
    return r10 ? 16'(v) : 16'(v >> 2);
  endfunction : exp_res
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge sys_clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 got = rdata;
  endtask : rd
  task automatic pulse(input logic b1);
    @(posedge sys_clk);
    trig <= b1 ? 2'b01 : 2'b10;
    @(posedge sys_clk);
    trig <= '0;
  endtask : pulse
  task automatic sweep_end(input int cnt, input logic r10, input logic [15:0] st);
    for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge sys_clk);
    chk("irq", 16'h1, 16'(irq));
    for (i = 0; i < cnt; i++) begin
      rd(OFS_RESULT_0 + 5'(i));
      chk("result", exp_res(3'(i), r10), got);
    end
    rd(OFS_IRQ_STAT);
    chk("irq_stat", st, got);
    wr(OFS_IRQ_CLR, 8'h07);
    rd(OFS_IRQ_STAT);
    chk("irq_stat_clr", 16'h0, got);
  endtask : sweep_end
  task automatic finish_test;
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  // ******************************
  // Scenarios
  // ******************************
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(OFS_CONTROL_1);
    chk("ctl1_rst", 16'(RST_CONTROL), got);
    rd(5'h0F);
    chk("unmapped", 16'h0, got);
    // Only completion drives the line, so ignored or restarting triggers cannot end a wait early
    wr(OFS_IRQ_EN, 8'h01);
    wr(OFS_CONTROL_2, 8'h06);
    wr(OFS_TRIG_CTRL, 8'h01);
    for (k = 0; k < 4; k++) begin
      wr(OFS_CONTROL_1, 8'(k) | (k[0] ? 8'h08 : 8'h00));
      slow <= 1'($random(seed));
      pulse(1'b0);
      pulse(1'b0);
      repeat (k == 0 ? 2 : 2 + ({$random(seed)} % 60)) @(posedge sys_clk);
      pulse(1'b1);
      sweep_end(2 * (k + 1), k[0], 16'h5);
    end
    // Abort during a later input restarts from input 0
    wr(OFS_CONTROL_1, 8'h0B);
    pulse(1'b0);
    pulse(1'b1);
    for (i = 0; i < 3000 && !(core_req.start === 1'b1 && core_req.chan === 3'h3); i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("group", 16'h3, 16'(core_req.group));
    pulse(1'b0);
    repeat (10) @(posedge sys_clk);
    pulse(1'b1);
    sweep_end(8, 1'b1, 16'h3);
    pulse(1'b0);
    rd(OFS_CONTROL_0);
    chk("start_flag", 16'h1, 16'(got[BIT_START]));
    wr(OFS_CONTROL_0, 8'h00);
    pulse(1'b1);
    repeat (100) @(posedge sys_clk);
    rd(OFS_STATUS_0);
    chk("busy", 16'h0, 16'(got[BIT_ST_BUSY]));
    rd(OFS_CONTROL_0);
    chk("start_flag", 16'h0, 16'(got[BIT_START]));
    chk("irq_off", 16'h0, 16'(irq));
    // Triggers with the trigger enable off must not start a sweep
    wr(OFS_TRIG_CTRL, 8'h00);
    pulse(1'b0);
    repeat (4) @(posedge sys_clk);
    rd(OFS_STATUS_0);
    chk("busy_off", 16'h0, 16'(got[BIT_ST_BUSY]));
    finish_test();
  end
  initial begin
    #600000;
    n_errors++;
    finish_test();
  end
endmodule : adcdt_sweep_bench
